/* sec_counters.sv */
// Safety error counters: monitor failure counter, device error counter,
// time-out flag, and clear-on-read status registers.
// Assumes all event inputs are single-cycle pulses on sys_clk; the state
// machine reports its state and acts on the request outputs.
`include "sec_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module sec_counters
#(
   parameter logic [3:0] OUT_DIS_TH   = `SEC_OUT_DIS_TH_DEF,
   parameter logic [3:0] MON_RST_TH   = `SEC_MON_RST_TH_DEF,
   parameter logic [3:0] SAFE_LOCK_THRESHOLD = `SEC_SAFE_LOCK_THRESHOLD_DEF,
   parameter logic [3:0] POWER_DOWN_THRESHOLD       = `SEC_POWER_DOWN_THRESHOLD_DEF
)
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   input  wire sec_pkg::sec_state_type dev_state,
   input  wire logic                  monitor_error,
   input  wire logic                  monitor_good_resp,
   input  wire logic                  self_test_done,
   input  wire logic                  monitor_config_mode,
   input  wire logic                  monitor_enable_bit,
   input  wire logic                  diag_timeout,
   input  wire logic                  cfg_lock,
   input  wire logic                  stat4_rd,
   input  wire logic                  stat4_wr,
   input  wire logic [7:0]            stat4_wdata,
   input  wire logic                  mon_rd,
   input  wire logic                  mon_wr,
   input  wire logic [7:0]            mon_wdata,
   input  wire logic                  xfer_rd,
   input  wire logic                  frame_end,
   input  wire logic [7:0]            frame_err,
   output logic      [7:0]            mon_rdata,
   output logic      [7:0]            stat4_rdata,
   output logic      [7:0]            xfer_rdata,
   output logic      [3:0]            monitor_failure_counter,
   output logic      [3:0]            device_error_counter,
   output logic                       req_safe,
   output logic                       req_reset,
   output logic                       req_off
);
   logic [3:0]                 mon_cnt_q;
   logic [3:0]                 dev_cnt_q;
   logic                       cfg_q;
   logic                       en_q;
   sec_pkg::sec_state_type     prev_state_q;
   logic                       enter_reset;
   logic                       enter_diag;
   logic                       enter_safe;
   logic                       ad_state;
   logic                       at_dis;
   logic                       at_rst;
   logic [2:0]                 mon_set;
   logic [2:0]                 mon_cond;
   logic [2:0]                 mon_flags;
   logic [0:0]                 to_flag;
   logic [7:0]                 frame_err_q;
   logic                       frame_end_q;
   logic [7:0]                 xfer_flags;

   function automatic logic [3:0] sat_step(input logic [3:0] v,
                                           input logic       up,
                                           input logic       dn);
      logic [3:0] r;
      r = v;
      if (up && !dn && v != 4'hf)
         r = v + 4'h1;
      else if (dn && !up && v != 4'h0)
         r = v - 4'h1;
      return r;
   endfunction : sat_step

   assign enter_reset = (dev_state == sec_pkg::SEC_ST_RESET) &&
                        (prev_state_q != sec_pkg::SEC_ST_RESET);
   assign enter_diag  = (dev_state == sec_pkg::SEC_ST_DIAG) &&
                        (prev_state_q != sec_pkg::SEC_ST_DIAG);
   assign enter_safe  = (dev_state == sec_pkg::SEC_ST_SAFE) &&
                        (prev_state_q != sec_pkg::SEC_ST_SAFE);
   assign ad_state    = (dev_state == sec_pkg::SEC_ST_ACTIVE) ||
                        (dev_state == sec_pkg::SEC_ST_DIAG);
   assign at_dis      = mon_cnt_q >= OUT_DIS_TH;
   assign at_rst      = mon_cnt_q >= MON_RST_TH;

   always_ff @(posedge sys_clk)
   begin
      // Edge detectors start at the present levels, so leaving reset in
      // SAFE or with the monitor enabled makes no false entry or rise
      if (!rst_n)
      begin
         prev_state_q <= dev_state;
         cfg_q        <= monitor_config_mode;
         en_q         <= monitor_enable_bit;
      end
      else
      begin
         prev_state_q <= dev_state;
         cfg_q        <= monitor_config_mode;
         en_q         <= monitor_enable_bit;
      end
   end

   // Monitor failure counter; reload has priority over counting
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         mon_cnt_q <= `SEC_MON_CNT_INIT;
      else if (enter_reset || enter_diag || self_test_done ||
               (cfg_q != monitor_config_mode) ||
               (monitor_enable_bit && !en_q))
         mon_cnt_q <= `SEC_MON_CNT_INIT;
      else if (mon_wr)
         mon_cnt_q <= mon_wdata[3:0];
      else
         mon_cnt_q <= sat_step(mon_cnt_q, monitor_error,
                               monitor_good_resp);
   end

   // Flags: failure, output disable, reset failure
   assign mon_set  = {at_rst, at_dis,
                      monitor_error | at_dis | at_rst};
   assign mon_cond = {at_rst, at_dis, at_dis | at_rst};

   sec_rc_flags #(.W(3)) u_mon_flags
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set_evt (mon_set),
      .cond    (mon_cond),
      .rd      (mon_rd),
      .flags   (mon_flags)
   );

   // Time-out flag has no lasting condition: one read clears it
   sec_rc_flags #(.W(1)) u_to_flag
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set_evt (diag_timeout),
      .cond    (1'b0),
      .rd      (stat4_rd),
      .flags   (to_flag)
   );

   // Device error counter
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         dev_cnt_q <= `SEC_DEV_CNT_INIT;
      else if (stat4_wr && dev_state == sec_pkg::SEC_ST_DIAG && !cfg_lock)
         dev_cnt_q <= stat4_wdata[3:0];
      else if (enter_safe &&
               (prev_state_q == sec_pkg::SEC_ST_DIAG ||
                prev_state_q == sec_pkg::SEC_ST_ACTIVE))
         dev_cnt_q <= sat_step(dev_cnt_q, 1'b1, 1'b0);
      else if (enter_safe && prev_state_q == sec_pkg::SEC_ST_RESET &&
               !(dev_cnt_q > SAFE_LOCK_THRESHOLD))
         dev_cnt_q <= sat_step(dev_cnt_q, 1'b1, 1'b0);
   end

   // Transition requests, one cycle after the counter settles
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         req_safe  <= 1'b0;
         req_reset <= 1'b0;
         req_off   <= 1'b0;
      end
      else
      begin
         req_reset <= at_rst && ad_state;
         req_safe  <= ad_state && !at_rst && (at_dis ||
                      (diag_timeout &&
                       dev_state == sec_pkg::SEC_ST_DIAG));
         req_off   <= dev_cnt_q == POWER_DOWN_THRESHOLD;
      end
   end

   // Transfer flags latch only at frame end, so the report is of the
   // frame just finished while a new one is still in flight
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         frame_err_q <= 8'h00;
         frame_end_q <= 1'b0;
      end
      else
      begin
         frame_end_q <= frame_end;
         if (frame_end)
            frame_err_q <= frame_err;
      end
   end

   sec_rc_flags #(.W(8)) u_xfer_flags
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set_evt (frame_end_q ? frame_err_q : 8'h00),
      .cond    (8'h00),
      .rd      (xfer_rd),
      .flags   (xfer_flags)
   );

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         mon_rdata               <= 8'h00;
         stat4_rdata             <= 8'h00;
         xfer_rdata              <= 8'h00;
         monitor_failure_counter <= `SEC_MON_CNT_INIT;
         device_error_counter    <= `SEC_DEV_CNT_INIT;
      end
      else
      begin
         mon_rdata               <= {1'b0, mon_flags, mon_cnt_q};
         stat4_rdata             <= {3'b000, to_flag, dev_cnt_q};
         xfer_rdata              <= xfer_flags;
         monitor_failure_counter <= mon_cnt_q;
         device_error_counter    <= dev_cnt_q;
      end
   end
endmodule : sec_counters
`default_nettype wire

/* sec_regs.svh */
// Register layout, reset values and field positions of the safety error
// counters block. Assumes inclusion by bare name from design files.
// Summary of operation
// - Monitor failure sets flag and increments counter
// - Monitor counter loads five on listed events
// - Counter up on error, down on good response
// - Counter at disable threshold: flags, request SAFE
// - Counter at reset threshold: flags, request RESET
// - Diagnostic time-out: flag, go SAFE, count error
// - Time-out flag latched until register read
// - Read clears flag only if condition gone
// - Device error counter increments entering SAFE
// - No increment RESET-to-SAFE above safe-lock threshold
// - Counter writable only in DIAGNOSTIC, unlocked
// - Counter at power-down threshold requests OFF
// - Status registers reset by power-on, clear-on-read
// - Transfer flags hold high until register read
// - Transfer flags report the previous frame
// - Disable and reset failure flags read-to-clear
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH
`define SEC_MON_CNT_INIT      4'h5
`define SEC_DEV_CNT_INIT      4'h0
`define SEC_MON_CNT_LSB       0
`define SEC_MON_FAIL_BIT      4
`define SEC_MON_DIS_BIT       5
`define SEC_MON_RST_BIT       6
`define SEC_STAT4_TO_BIT      4
`define SEC_OUT_DIS_TH_DEF    4'h8
`define SEC_MON_RST_TH_DEF    4'hc
`define SEC_SAFE_LOCK_THRESHOLD_DEF  4'h4
`define SEC_POWER_DOWN_THRESHOLD_DEF        4'hf
`endif

/* sec_pkg.sv */
// Types shared by the safety error counters block.
// Assumes sec_regs.svh for numeric constants.
package sec_pkg;
   typedef enum logic [4:0]
   {
      SEC_ST_OFF    = 5'b00001,
      SEC_ST_RESET  = 5'b00010,
      SEC_ST_DIAG   = 5'b00100,
      SEC_ST_ACTIVE = 5'b01000,
      SEC_ST_SAFE   = 5'b10000
   } sec_state_type;
endpackage : sec_pkg

/* sec_rc_flags.sv */
// Read-to-clear sticky flag bank.
// Assumes set and condition inputs are on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module sec_rc_flags
#(
   parameter int W = 8
)
(
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] set_evt,
   input  wire logic [W-1:0] cond,
   input  wire logic         rd,
   output logic      [W-1:0] flags
);
   // A set in the read cycle wins; a still-present condition survives
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         flags <= '0;
      else if (rd)
         flags <= set_evt | (flags & cond);
      else
         flags <= flags | set_evt;
   end
endmodule : sec_rc_flags
`default_nettype wire

/* sec_counters_sva.sv */
// Checker for the safety error counters, watching top-level ports only.
// Assumes one sys_clk domain with a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module sec_counters_chk
#(
   parameter logic [3:0] OUT_DIS_TH = 4'h8,
   parameter logic [3:0] MON_RST_TH = 4'hc,
   parameter logic [3:0] POWER_DOWN_THRESHOLD     = 4'hf
)
(
   input wire logic                   sys_clk,
   input wire logic                   rst_n,
   input wire sec_pkg::sec_state_type dev_state,
   input wire logic                   monitor_error,
   input wire logic                   monitor_good_resp,
   input wire logic                   self_test_done,
   input wire logic                   monitor_config_mode,
   input wire logic                   monitor_enable_bit,
   input wire logic                   mon_wr,
   input wire logic [7:0]             mon_rdata,
   input wire logic [3:0]             monitor_failure_counter,
   input wire logic [3:0]             device_error_counter,
   input wire logic                   req_safe,
   input wire logic                   req_reset,
   input wire logic                   req_off
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sec_pkg::sec_state_type st_q;
   logic                   cfg_q;
   logic                   en_q;
   logic                   calm;
   always_ff @(posedge sys_clk)
   begin
      st_q <= dev_state;
      cfg_q <= monitor_config_mode;
      en_q <= monitor_enable_bit;
   end
   // Counting is only predictable when no reload or write competes
   assign calm = dev_state == st_q && monitor_config_mode == cfg_q &&
      (en_q || !monitor_enable_bit) && !self_test_done && !mon_wr;
   a_err_flag: assert property (
      monitor_error && !monitor_good_resp |-> ##2 mon_rdata[4])
      else $error("fail flag not set");
   a_cnt_up: assert property (
      monitor_error && !monitor_good_resp && calm |-> ##2
      (monitor_failure_counter == $past(monitor_failure_counter) + 4'h1
      || $past(monitor_failure_counter) == 4'hf))
      else $error("counter did not step up");
   a_cnt_down: assert property (
      monitor_good_resp && !monitor_error && calm |-> ##2
      (monitor_failure_counter == $past(monitor_failure_counter) - 4'h1
      || $past(monitor_failure_counter) == 4'h0))
      else $error("counter did not step down");
   a_reload_five: assert property (
      self_test_done |-> ##2 monitor_failure_counter == 4'h5)
      else $error("counter not reloaded");
   a_safe_req: assert property (
      $stable(dev_state)[*3] ##0 dev_state == sec_pkg::SEC_ST_ACTIVE &&
      monitor_failure_counter >= OUT_DIS_TH &&
      monitor_failure_counter < MON_RST_TH |-> req_safe)
      else $error("safe request missing");
   a_reset_req: assert property (
      $stable(dev_state)[*3] ##0 dev_state == sec_pkg::SEC_ST_ACTIVE &&
      monitor_failure_counter >= MON_RST_TH |-> req_reset)
      else $error("reset request missing");
   a_dev_inc: assert property (
      dev_state == sec_pkg::SEC_ST_SAFE &&
      $past(dev_state) inside {sec_pkg::SEC_ST_DIAG, sec_pkg::SEC_ST_ACTIVE}
      |-> ##2 device_error_counter == $past(device_error_counter) + 4'h1)
      else $error("device counter did not step");
   a_off_req: assert property (
      device_error_counter == POWER_DOWN_THRESHOLD |-> req_off)
      else $error("off request missing");
endmodule : sec_counters_chk
bind sec_counters sec_counters_chk #(.OUT_DIS_TH(OUT_DIS_TH),
   .MON_RST_TH(MON_RST_TH), .POWER_DOWN_THRESHOLD(POWER_DOWN_THRESHOLD)) chk_u (.*);
`default_nettype wire

/* sec_mcu_model.sv */
// Supervising controller model: issues each register read as two one-cycle pulses.
// Assumes calls come from the bench's driving process at a falling edge.
`timescale 1ns/10ps
`default_nettype none
module sec_mcu_model
(
   input  wire logic sys_clk,
   output logic      mon_rd,
   output logic      stat4_rd,
   output logic      xfer_rd
);
   initial {xfer_rd, stat4_rd, mon_rd} = 3'b000;
   // Read pulse is repeated once, one idle cycle after the first; the task checks nothing
   task automatic read(input logic [1:0] s);
      repeat (2)
      begin
         {xfer_rd, stat4_rd, mon_rd} = 3'b001 << s;
         @(negedge sys_clk);
         {xfer_rd, stat4_rd, mon_rd} = 3'b000;
         @(negedge sys_clk);
      end
   endtask : read
endmodule : sec_mcu_model
`default_nettype wire

/* sec_counters_bench.sv */
// Bench for the safety error counters; results are queued and checked.
// Assumes outputs settle within three clocks after the inputs are taken.
`timescale 1ns/10ps
`default_nettype none
module sec_counters_bench;
   typedef struct {int s; logic [7:0] e;} sec_note_type;
   logic sys_clk, rst_n, monitor_error, monitor_good_resp, self_test_done;
   logic diag_timeout, cfg_lock, stat4_wr, frame_end, mon_rd, stat4_rd;
   logic xfer_rd, req_safe, req_reset, req_off;
   logic monitor_config_mode, monitor_enable_bit, mon_wr;
   logic [7:0] stat4_wdata, frame_err, mon_rdata, stat4_rdata, xfer_rdata;
   logic [7:0] mon_wdata, r;
   logic [3:0] monitor_failure_counter, device_error_counter;
   logic [7:0] o [5];
   sec_pkg::sec_state_type dev_state;
   sec_note_type q [$];
   int n_fail = 0, n_compared = 0, seed = 32'hcae1;
   sec_counters dut_u (.sys_clk, .rst_n, .dev_state, .monitor_error,
      .monitor_good_resp, .self_test_done, .monitor_config_mode,
      .monitor_enable_bit, .diag_timeout, .cfg_lock, .stat4_rd,
      .stat4_wr, .stat4_wdata, .mon_rd, .mon_wr, .mon_wdata,
      .xfer_rd, .frame_end, .frame_err, .mon_rdata, .stat4_rdata,
      .xfer_rdata, .monitor_failure_counter, .device_error_counter,
      .req_safe, .req_reset, .req_off);
   sec_mcu_model mcu_u (.sys_clk, .mon_rd, .stat4_rd, .xfer_rd);
   assign o[0] = mon_rdata;
   assign o[1] = stat4_rdata;
   assign o[2] = xfer_rdata;
   assign o[3] = {5'h00, req_off, req_reset, req_safe};
   assign o[4] = {monitor_failure_counter, device_error_counter};
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic step(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : step
   task automatic note(input int s, input logic [7:0] e);
      step(3);
      q.push_back('{s, e});
   endtask : note
   task automatic finish_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   initial
   begin
      forever
      begin
         @(posedge sys_clk);
         #2;
         while (q.size() > 0)
         begin
            n_compared++;
            if (o[q[0].s] !== q[0].e)
            begin
               n_fail++;
               $display("Error %0t: out %0d is %h not %h", $time, q[0].s,
                  o[q[0].s], q[0].e);
            end
            void'(q.pop_front());
         end
      end
   end
   initial
   begin
      repeat (2000) @(posedge sys_clk);
      n_fail++;
      finish_test();
   end
   initial
   begin
      {monitor_error, monitor_good_resp, self_test_done, diag_timeout} = '0;
      {cfg_lock, stat4_wr, frame_end, stat4_wdata, frame_err} = '0;
      {monitor_config_mode, mon_wr, mon_wdata} = '0;
      monitor_enable_bit = 1'b1;
      dev_state = sec_pkg::SEC_ST_ACTIVE;
      rst_n = 1'b0;
      step(4);
      rst_n = 1'b1;
      note(0, 8'h05);
      note(1, 8'h00);
      note(4, 8'h50);
      monitor_error = 1'b1;
      step(3);
      monitor_error = 1'b0;
      note(0, 8'h38);
      note(3, 8'h01);
      monitor_error = 1'b1;
      step(4);
      monitor_error = 1'b0;
      note(3, 8'h02);
      mcu_u.read(2'd0);
      note(0, 8'h7c);
      monitor_good_resp = 1'b1;
      step(8);
      monitor_good_resp = 1'b0;
      note(0, 8'h74);
      note(3, 8'h00);
      mcu_u.read(2'd0);
      note(0, 8'h04);
      self_test_done = 1'b1;
      step(1);
      self_test_done = 1'b0;
      note(0, 8'h05);
      dev_state = sec_pkg::SEC_ST_DIAG;
      step(2);
      diag_timeout = 1'b1;
      step(1);
      diag_timeout = 1'b0;
      dev_state = sec_pkg::SEC_ST_SAFE;
      note(1, 8'h11);
      mcu_u.read(2'd1);
      note(1, 8'h01);
      dev_state = sec_pkg::SEC_ST_DIAG;
      {cfg_lock, stat4_wr, stat4_wdata} = {2'b11, 8'hf6};
      note(1, 8'h01);
      cfg_lock = 1'b0;
      step(1);
      stat4_wr = 1'b0;
      note(1, 8'h06);
      dev_state = sec_pkg::SEC_ST_RESET;
      step(2);
      dev_state = sec_pkg::SEC_ST_SAFE;
      note(1, 8'h06);
      dev_state = sec_pkg::SEC_ST_DIAG;
      {stat4_wr, stat4_wdata} = {1'b1, 8'h0e};
      step(1);
      stat4_wr = 1'b0;
      step(1);
      dev_state = sec_pkg::SEC_ST_SAFE;
      note(1, 8'h0f);
      note(4, 8'h5f);
      note(3, 8'h04);
      r = 8'($random(seed));
      {frame_end, frame_err} = {1'b1, r};
      step(1);
      {frame_end, frame_err} = {1'b1, 8'h00};
      step(1);
      frame_end = 1'b0;
      note(2, r);
      note(2, r);
      mcu_u.read(2'd2);
      note(2, 8'h00);
      // Counter write with the enable low, then the enable rise reloads
      {mon_wr, mon_wdata, monitor_enable_bit} = {1'b1, 8'h0a, 1'b0};
      step(1);
      mon_wr = 1'b0;
      note(0, 8'h3a);
      note(4, 8'haf);
      monitor_enable_bit = 1'b1;
      note(4, 8'h5f);
      // Counter write, then a configuration toggle reloads
      {mon_wr, mon_wdata} = {1'b1, 8'h0c};
      step(1);
      mon_wr = 1'b0;
      monitor_config_mode = 1'b1;
      note(4, 8'h5f);
      note(0, 8'h75);
      // Below the safe-lock level (count 3) a RESET-to-SAFE move still counts
      dev_state = sec_pkg::SEC_ST_DIAG;
      {stat4_wr, stat4_wdata} = {1'b1, 8'h03};
      step(1);
      stat4_wr = 1'b0;
      dev_state = sec_pkg::SEC_ST_RESET;
      step(2);
      dev_state = sec_pkg::SEC_ST_SAFE;
      note(4, 8'h54);
      while (q.size() > 0)
         step(1);
      finish_test();
   end
endmodule : sec_counters_bench
`default_nettype wire
